// File: hdl/rotc_pkg.sv
// package: constants and types of the rc oscillator trim calibrator
// Function
// - pulse while counting down means slow clock, while counting up means fast clock
// - auto-adjust bit 6 set lets hardware step the trim code on each evaluated pulse between one and 128 limits
// - pulse below limit sets ok flag, trim code untouched
// - pulse within limit to three limits sets ok flag, trim steps by one
// - pulse within three to 128 limits sets warn flag, trim steps by two
// - pulse counting down at or above 128 limits sets error flag only
// - counter counting up reaching 128 limits sets reference-missing flag
// - trim saturates at 0 and 127, setting trim-range error flag
// - software writes trim code only while auto-adjust is clear
// - trim code resets to 64; each step nudges frequency one step
// - writing one to bit 7 injects one pulse; reads back zero
// - bit 5 runs the counter and locks the config register
// - each pulse reloads and counts down; else down, up, then hold
// - each pulse while the counter runs captures count and direction into status
// - soft pulse and external pulse are ORed into one sync pulse
package rotc_pkg;

  // ==========================================================
  // register map
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] OFF_CTRL = 4'h0;
  localparam logic [AXI_AW-1:0] OFF_CFG = 4'h4;
  localparam logic [AXI_AW-1:0] OFF_STAT = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // calibration_control fields
  localparam int B_OK_IE = 0;
  localparam int B_WARN_IE = 1;
  localparam int B_ERR_IE = 2;
  localparam int B_EREF_IE = 3;
  localparam int B_RUN = 5;
  localparam int B_AUTO = 6;
  localparam int B_SOFT = 7;
  localparam int TRIM_LSB = 8;
  localparam int TRIM_W = 7;
  localparam logic [31:0] CTRL_RST = 32'h0000_4000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_7f6f;
  localparam logic [TRIM_W-1:0] TRIM_MAX = 7'h7f;

  // ==========================================================
  // calibration_config fields
  localparam int B_REFPOL = 31;
  localparam int LIM_LSB = 16;
  localparam int LIM_W = 8;
  localparam int RLD_W = 16;
  localparam logic [31:0] CFG_RST = 32'h2022_bb7f;
  localparam logic [31:0] CFG_WMASK = 32'hb7ff_ffff;

  // ==========================================================
  // calibration_status fields
  localparam int S_OK = 0;
  localparam int S_WARN = 1;
  localparam int S_ERR = 2;
  localparam int S_EREF = 3;
  localparam int S_CAL_ERROR_FLAG = 8;
  localparam int S_MISS = 9;
  localparam int S_TRIM_RANGE_ERROR_FLAG = 10;
  localparam int S_DIR = 15;
  localparam int S_CAP_LSB = 16;

  // ==========================================================
  // evaluation limits: 3x and 128x the tolerance limit
  localparam int WARN_MULT = 3;
  localparam int MISS_SHIFT = 7;

  typedef enum logic [1:0] {
    ROTC_IDLE = 2'b00,
    ROTC_DOWN = 2'b01,
    ROTC_UP = 2'b10,
    ROTC_HOLD = 2'b11
  } rotc_cnt_st_t;

  typedef struct packed {
    logic ok;
    logic warn;
    logic eref;
    logic cal_error_flag;
    logic miss;
    logic trim_range_error_flag;
  } rotc_flags_t;

  typedef struct packed {
    logic [AXI_AW-1:0] aw_addr;
    logic aw_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_got;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [31:0] cfg;
    logic soft_pulse;
    rotc_flags_t flags;
    logic [RLD_W-1:0] cap;
    logic cap_up;
    logic [2:0] ref_sync;
  } rotc_state_t;

  typedef struct packed {
    rotc_cnt_st_t st;
    logic [RLD_W-1:0] cnt;
  } rotc_cnt_state_t;

endpackage

// File: hdl/rotc_counter.sv
// calibration counter: reload and count down, then up to 128 limits, then hold
`timescale 1ns/1ps
module rotc_counter import rotc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic sync_pulse,
  input wire logic [RLD_W-1:0] reload,
  input wire logic [LIM_W-1:0] limit,
  output logic [RLD_W-1:0] count,
  output logic count_up,
  output logic running,
  output logic miss
);

  rotc_cnt_state_t r_r;
  rotc_cnt_state_t r_nxt;
  logic [RLD_W-1:0] top;

  // 128 x limit fits the 16-bit counter since the limit is 8 bits
  assign top = RLD_W'({limit, 7'h00});
  assign count = r_r.cnt;
  assign count_up = (r_r.st == ROTC_UP) || (r_r.st == ROTC_HOLD);
  assign running = r_r.st != ROTC_IDLE;
  assign miss = (r_r.st == ROTC_UP) && (r_r.cnt == top) && !sync_pulse;

  // ==========================================================
  // next state
  always_comb begin
    r_nxt = r_r;
    if (!run) begin
      r_nxt.st = ROTC_IDLE;
      r_nxt.cnt = '0;
    end else if (sync_pulse) begin
      r_nxt.st = ROTC_DOWN;
      r_nxt.cnt = reload;
    end else begin
      case (r_r.st)
        ROTC_DOWN: begin
          if (r_r.cnt == '0) begin
            r_nxt.st = ROTC_UP;
          end else begin
            r_nxt.cnt = r_r.cnt - 16'h0001;
          end
        end
        ROTC_UP: begin
          if (r_r.cnt == top) begin
            r_nxt.st = ROTC_HOLD;
          end else begin
            r_nxt.cnt = r_r.cnt + 16'h0001;
          end
        end
        default: begin
          r_nxt = r_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_r <= '{st: ROTC_IDLE, cnt: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

endmodule

// File: hdl/rotc_calibrator.sv
// top: axi4-lite registers, frequency evaluation and automatic trim
`timescale 1ns/1ps
module rotc_calibrator import rotc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic ref_pin,
  output logic [TRIM_W-1:0] trim_code,
  output logic irq,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  rotc_state_t r_r;
  rotc_state_t r_nxt;

  logic [RLD_W-1:0] cnt;
  logic cnt_up;
  logic cnt_running;
  logic cnt_miss;
  logic ext_edge;
  logic sync_pulse;
  logic eval;
  logic auto_on;
  logic [LIM_W-1:0] lim;
  logic [RLD_W-1:0] lim3;
  logic [RLD_W-1:0] lim128;
  logic [1:0] region;
  logic [1:0] step;
  logic [8:0] trim_sum;
  logic wr_do;
  logic wr_ctrl;
  logic [31:0] wmask;
  logic [31:0] stat_word;

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // ==========================================================
  // reference pulse: external edge plus software pulse
  // ref_sync[0] feeds only ref_sync[1]; edge is taken between stages 1 and 2
  assign ext_edge = r_r.cfg[B_REFPOL] ? (r_r.ref_sync[2] && !r_r.ref_sync[1])
                                      : (r_r.ref_sync[1] && !r_r.ref_sync[2]);
  assign sync_pulse = r_r.soft_pulse || ext_edge;

  rotc_counter u_counter (
    .clk(clk),
    .rst(rst),
    .run(r_r.ctrl[B_RUN]),
    .sync_pulse(sync_pulse),
    .reload(r_r.cfg[RLD_W-1:0]),
    .limit(lim),
    .count(cnt),
    .count_up(cnt_up),
    .running(cnt_running),
    .miss(cnt_miss)
  );

  // ==========================================================
  // evaluation windows
  // the first pulse after enabling only starts the counter, nothing to judge
  assign eval = sync_pulse && cnt_running;
  assign auto_on = r_r.ctrl[B_AUTO];
  assign lim = r_r.cfg[LIM_LSB +: LIM_W];
  assign lim3 = RLD_W'(WARN_MULT * lim);
  assign lim128 = RLD_W'({lim, 7'h00});

  always_comb begin
    if (cnt < RLD_W'(lim)) begin
      region = 2'h0;
      step = 2'h0;
    end else if (cnt < lim3) begin
      region = 2'h1;
      step = 2'h1;
    end else if (cnt < lim128) begin
      region = 2'h2;
      step = 2'h2;
    end else begin
      region = 2'h3;
      step = 2'h0;
    end
  end

  // down means slow clock so trim rises, up means fast so trim falls
  assign trim_sum = cnt_up ? ({2'h0, r_r.ctrl[TRIM_LSB +: TRIM_W]} - {7'h00, step})
                           : ({2'h0, r_r.ctrl[TRIM_LSB +: TRIM_W]} + {7'h00, step});

  // ==========================================================
  // register bus
  assign s_axi_awready = !r_r.aw_got && !r_r.bvalid;
  assign s_axi_wready = !r_r.w_got && !r_r.bvalid;
  assign s_axi_bvalid = r_r.bvalid;
  assign s_axi_bresp = r_r.bresp;
  assign s_axi_arready = !r_r.rvalid;
  assign s_axi_rvalid = r_r.rvalid;
  assign s_axi_rdata = r_r.rdata;
  assign s_axi_rresp = r_r.rresp;
  assign wr_do = r_r.aw_got && r_r.w_got && !r_r.bvalid;
  assign wr_ctrl = wr_do && (r_r.aw_addr == OFF_CTRL);
  assign wmask = strb_mask(r_r.wstrb);

  assign stat_word = {r_r.cap, r_r.cap_up, 4'h0, r_r.flags.trim_range_error_flag, r_r.flags.miss,
                      r_r.flags.cal_error_flag, 4'h0, r_r.flags.eref,
                      r_r.flags.cal_error_flag || r_r.flags.miss || r_r.flags.trim_range_error_flag,
                      r_r.flags.warn, r_r.flags.ok};

  assign trim_code = r_r.ctrl[TRIM_LSB +: TRIM_W];

  assign irq = (r_r.flags.ok && r_r.ctrl[B_OK_IE]) ||
               (r_r.flags.warn && r_r.ctrl[B_WARN_IE]) ||
               (stat_word[S_ERR] && r_r.ctrl[B_ERR_IE]) ||
               (r_r.flags.eref && r_r.ctrl[B_EREF_IE]);

  // ==========================================================
  // next state
  always_comb begin
    logic [31:0] wbits;
    wbits = '0;
    r_nxt = r_r;
    r_nxt.soft_pulse = 1'b0;
    r_nxt.ref_sync = {r_r.ref_sync[1:0], ref_pin};

    // write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      r_nxt.aw_got = 1'b1;
      r_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_nxt.w_got = 1'b1;
      r_nxt.wdata = s_axi_wdata;
      r_nxt.wstrb = s_axi_wstrb;
    end
    if (r_r.bvalid && s_axi_bready) begin
      r_nxt.bvalid = 1'b0;
    end

    if (wr_do) begin
      r_nxt.aw_got = 1'b0;
      r_nxt.w_got = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp = RESP_OKAY;
      wbits = r_r.wdata & wmask;
      if (r_r.aw_addr == OFF_CTRL) begin
        r_nxt.ctrl = (r_r.ctrl & ~(CTRL_WMASK & wmask)) | (wbits & CTRL_WMASK);
        if (auto_on) begin
          r_nxt.ctrl[TRIM_LSB +: TRIM_W] = r_r.ctrl[TRIM_LSB +: TRIM_W];
        end
        r_nxt.soft_pulse = wbits[B_SOFT];
      end else if (r_r.aw_addr == OFF_CFG) begin
        if (!r_r.ctrl[B_RUN]) begin
          r_nxt.cfg = (r_r.cfg & ~(CFG_WMASK & wmask)) | (wbits & CFG_WMASK);
        end
      end else if (r_r.aw_addr == OFF_STAT) begin
        // writing one clears; the summary error bit clears all three causes
        if (wbits[S_OK]) r_nxt.flags.ok = 1'b0;
        if (wbits[S_WARN]) r_nxt.flags.warn = 1'b0;
        if (wbits[S_EREF]) r_nxt.flags.eref = 1'b0;
        if (wbits[S_CAL_ERROR_FLAG] || wbits[S_ERR]) r_nxt.flags.cal_error_flag = 1'b0;
        if (wbits[S_MISS] || wbits[S_ERR]) r_nxt.flags.miss = 1'b0;
        if (wbits[S_TRIM_RANGE_ERROR_FLAG] || wbits[S_ERR]) r_nxt.flags.trim_range_error_flag = 1'b0;
      end else begin
        r_nxt.bresp = RESP_SLVERR;
      end
    end

    if (r_r.rvalid && s_axi_rready) begin
      r_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp = RESP_OKAY;
      if (s_axi_araddr == OFF_CTRL) begin
        r_nxt.rdata = r_r.ctrl;
      end else if (s_axi_araddr == OFF_CFG) begin
        r_nxt.rdata = r_r.cfg;
      end else if (s_axi_araddr == OFF_STAT) begin
        r_nxt.rdata = stat_word;
      end else begin
        r_nxt.rdata = '0;
        r_nxt.rresp = RESP_SLVERR;
      end
    end

    // hardware sets come last so a set beats a clear in the same cycle
    if (eval) begin
      r_nxt.cap = cnt;
      r_nxt.cap_up = cnt_up;
      r_nxt.flags.eref = 1'b1;
      case (region)
        2'h0: r_nxt.flags.ok = 1'b1;
        2'h1: r_nxt.flags.ok = 1'b1;
        2'h2: r_nxt.flags.warn = 1'b1;
        default: begin
          if (!cnt_up) begin
            r_nxt.flags.cal_error_flag = 1'b1;
          end
        end
      endcase
      if (auto_on && (step != 2'h0)) begin
        if (trim_sum[8]) begin
          r_nxt.ctrl[TRIM_LSB +: TRIM_W] = '0;
          r_nxt.flags.trim_range_error_flag = 1'b1;
        end else if (trim_sum[7]) begin
          r_nxt.ctrl[TRIM_LSB +: TRIM_W] = TRIM_MAX;
          r_nxt.flags.trim_range_error_flag = 1'b1;
        end else begin
          r_nxt.ctrl[TRIM_LSB +: TRIM_W] = trim_sum[TRIM_W-1:0];
        end
      end
    end
    if (cnt_miss) begin
      r_nxt.flags.miss = 1'b1;
    end
    r_nxt.ctrl[B_SOFT] = 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_r <= '0;
      r_r.ctrl <= CTRL_RST;
      r_r.cfg <= CFG_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [TRIM_W-1:0] trim_now;
  assign trim_now = r_r.ctrl[TRIM_LSB +: TRIM_W];

  sequence s_auto_eval;
    eval && auto_on;
  endsequence

  sequence s_step_one_down;
    s_auto_eval ##0 (region == 2'h1) && !cnt_up && (trim_now != TRIM_MAX);
  endsequence

  sequence s_step_two_up;
    s_auto_eval ##0 (region == 2'h2) && cnt_up && (trim_now > 7'h01);
  endsequence

  a_manual_trim_hold: assert property (
    !auto_on && !wr_ctrl |=> $stable(trim_now))
    else $error("trim moved without auto-adjust or a write");

  a_ok_trim_kept: assert property (
    s_auto_eval ##0 (region == 2'h0) |=> r_r.flags.ok && $stable(trim_now))
    else $error("ok window changed trim or missed flag");

  a_step_one: assert property (
    s_step_one_down |=> r_r.flags.ok && (trim_now == $past(trim_now) + 7'h01))
    else $error("trim did not rise by one");

  a_step_two: assert property (
    s_step_two_up |=> r_r.flags.warn && (trim_now == $past(trim_now) - 7'h02))
    else $error("trim did not fall by two");

  a_cal_error_flag_set: assert property (
    eval && (region == 2'h3) && !cnt_up |=> r_r.flags.cal_error_flag && $stable(trim_now))
    else $error("error flag not set on late pulse");

  a_miss_set: assert property (
    cnt_miss |=> r_r.flags.miss ##1 !cnt_miss)
    else $error("missing reference not flagged once");

  a_trim_sat: assert property (
    s_auto_eval ##0 (region == 2'h2) && !cnt_up && (trim_now >= 7'h7e)
    |=> (trim_now == TRIM_MAX) && r_r.flags.trim_range_error_flag)
    else $error("trim overflow not saturated");

  a_auto_write_lock: assert property (
    wr_ctrl && auto_on && !eval |=> $stable(trim_now))
    else $error("software changed trim under auto-adjust");

  a_soft_pulse: assert property (
    wr_ctrl && r_r.wdata[B_SOFT] && r_r.wstrb[0]
    |=> sync_pulse ##1 !r_r.soft_pulse && !r_r.ctrl[B_SOFT])
    else $error("soft pulse not injected once");

  a_cfg_locked: assert property (
    r_r.ctrl[B_RUN] && wr_do |=> $stable(r_r.cfg))
    else $error("config changed while counter runs");

  a_irq_level: assert property (
    (r_r.flags.warn && r_r.ctrl[B_WARN_IE]) || (r_r.flags.miss && r_r.ctrl[B_ERR_IE]) |-> irq)
    else $error("enabled flag without interrupt");

  // the opposite directions of the two steps, and the floor of the range
  sequence s_step_one_up;
    s_auto_eval ##0 (region == 2'h1) && cnt_up && (trim_now != 7'h00);
  endsequence

  sequence s_step_two_down;
    s_auto_eval ##0 (region == 2'h2) && !cnt_up && (trim_now < 7'h7e);
  endsequence

  sequence s_trim_floor;
    s_auto_eval ##0 (region == 2'h2) && cnt_up && (trim_now < 7'h02);
  endsequence

  a_step_one_up: assert property (
    s_step_one_up |=> r_r.flags.ok && (trim_now == $past(trim_now) - 7'h01))
    else $error("trim did not fall by one");

  a_step_two_down: assert property (
    s_step_two_down |=> r_r.flags.warn && (trim_now == $past(trim_now) + 7'h02))
    else $error("trim did not rise by two");

  a_trim_floor: assert property (
    s_trim_floor |=> (trim_now == 7'h00) && r_r.flags.trim_range_error_flag)
    else $error("trim underflow not saturated");

  a_cap_taken: assert property (
    eval |=> (r_r.cap == $past(cnt)) && (r_r.cap_up == $past(cnt_up)))
    else $error("count or direction not captured");

  a_pulse_reload: assert property (
    sync_pulse && r_r.ctrl[B_RUN] |=> (cnt == $past(r_r.cfg[RLD_W-1:0])) && !cnt_up)
    else $error("pulse did not reload the counter");

  a_count_hold: assert property (
    cnt_up && (cnt == lim128) && r_r.ctrl[B_RUN] && !sync_pulse |=> $stable(cnt) && cnt_up)
    else $error("counter left the hold point without a pulse");

  a_cfg_open: assert property (
    !r_r.ctrl[B_RUN] && wr_do && (r_r.aw_addr == OFF_CFG) && (r_r.wstrb == 4'hf)
    |=> r_r.cfg == (($past(r_r.wdata) & CFG_WMASK) | ($past(r_r.cfg) & ~CFG_WMASK)))
    else $error("config write lost while counter stopped");

  a_irq_err: assert property (
    (r_r.flags.cal_error_flag || r_r.flags.trim_range_error_flag) && r_r.ctrl[B_ERR_IE] |-> irq)
    else $error("enabled error without interrupt");

endmodule

// File: dv/rotc_ref_model.sv
// partner model: external reference pulse source and oscillator trim receiver
`timescale 1ns/1ps
module rotc_ref_model import rotc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [TRIM_W-1:0] trim_code,
  output logic ref_pin
);
  // ==========================================================
  // pulse source
  // pin idles low; high for four cycles so the two-flop synchroniser sees a clean edge
  logic [2:0] hold_r;
  int osc_offset;

  initial begin
    ref_pin = 1'h0;
    hold_r = 3'h0;
  end

  // callers keep pulses at least ten cycles apart, so hold_r is idle here
  task automatic send_edge();
    ref_pin <= 1'h1;
    hold_r <= 3'h4;
  endtask

  always @(posedge clk) begin
    if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
      if (hold_r == 3'h1) ref_pin <= 1'h0;
    end
  end

  // ==========================================================
  // oscillator side: offset from the midpoint in trim steps
  always @(trim_code or rst) begin
    osc_offset = int'(trim_code) - 64;
  end
endmodule

// File: dv/tb_top.sv
// testbench: register access, evaluation regions, auto trim and interrupts
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module tb_top import rotc_pkg::*; ;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [AXI_AW-1:0] awaddr = '0;
  logic [AXI_AW-1:0] araddr = '0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'h0;
  logic [31:0] rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, ref_pin, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [TRIM_W-1:0] trim_code;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t_last = 0;

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  rotc_calibrator u_dut (.clk(clk), .rst(rst), .ref_pin(ref_pin), .trim_code(trim_code),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  rotc_ref_model u_ref (.clk(clk), .rst(rst), .trim_code(trim_code), .ref_pin(ref_pin));

  // ==========================================================
  // bus tasks
  task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 1'h0;
    dd = 1'h0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awready && !ad) begin
        ad = 1'h1;
        awvalid <= 1'h0;
      end
      if (wready && !dd) begin
        dd = 1'h1;
        wvalid <= 1'h0;
      end
    end
    while (bvalid !== 1'h1) @(posedge clk);
    rsp = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd_reg(input logic [AXI_AW-1:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    @(posedge clk);
    while (arready !== 1'h1) @(posedge clk);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1) @(posedge clk);
    rd = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask

  task automatic chk_reg(input logic [AXI_AW-1:0] a, input logic [31:0] e);
    rd_reg(a);
    `CHK("rdata", e, rd)
  endtask

  // one evaluated pulse a set gap after the last one, then status, trim and irq
  task automatic eval(input int gap, input logic [31:0] st, input logic [6:0] tr,
    input logic ir, input int ce, input logic up);
    while (cyc < t_last + gap) @(posedge clk);
    u_ref.send_edge();
    t_last = cyc;
    repeat (8) @(posedge clk);
    rd_reg(OFF_STAT);
    `CHK("status", st, rd & 32'h0000_0707)
    `CHK("trim", tr, trim_code)
    `CHK("irq", ir, irq)
    `CHK("cap", 1'h1, (int'(rd[31:16]) >= ce - 5) && (int'(rd[31:16]) <= ce + 5))
    if (ce > 5) `CHK("dir", up, rd[S_DIR])
    wr(OFF_STAT, 32'hffff_ffff);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // watchdog: the sequence needs about 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("watchdog expired");
    give_verdict();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    `CHK("trim", 7'h40, trim_code)
    `CHK("offset", 0, u_ref.osc_offset)
    chk_reg(OFF_CTRL, 32'h0000_4000);
    chk_reg(OFF_CFG, 32'h2022_bb7f);
    chk_reg(OFF_STAT, 32'h0000_0000);
    rd_reg(4'hc);
    `CHK("rresp", 2'h2, rsp)
    wr(4'hc, 32'hffff_ffff);
    `CHK("bresp", 2'h2, rsp)
    $display("test reset done");
    // limit 4, reload 100: pin pulses every 101 cycles are on frequency
    wr(OFF_CFG, 32'h0004_0064);
    wr(OFF_CTRL, 32'h0000_4061);
    u_ref.send_edge();
    t_last = cyc;
    wr(OFF_CTRL, 32'h0000_1061);
    chk_reg(OFF_CTRL, 32'h0000_4061);
    wr(OFF_CFG, 32'h0004_0258);
    chk_reg(OFF_CFG, 32'h0004_0064);
    eval(100, 32'h001, 7'h40, 1'h1, 0, 1'h0);
    eval(93, 32'h001, 7'h41, 1'h1, 7, 1'h0);
    eval(108, 32'h001, 7'h40, 1'h1, 7, 1'h1);
    eval(50, 32'h002, 7'h42, 1'h0, 50, 1'h0);
    eval(151, 32'h002, 7'h40, 1'h0, 50, 1'h1);
    $display("test regions done");
    while (cyc < t_last + 750) @(posedge clk);
    rd_reg(OFF_STAT);
    `CHK("status", 32'h204, rd & 32'h0000_0707)
    `CHK("irq", 1'h0, irq)
    wr(OFF_CTRL, 32'h0000_4065);
    `CHK("irq", 1'h1, irq)
    wr(OFF_STAT, 32'hffff_ffff);
    `CHK("irq", 1'h0, irq)
    `CHK("trim", 7'h40, trim_code)
    $display("test missing reference done");
    // manual trim while the counter is stopped, away from any pulse
    // the trim field takes a write only once auto-adjust is already off
    wr(OFF_CTRL, 32'h0000_7f05);
    `CHK("trim", 7'h40, trim_code)
    wr(OFF_CTRL, 32'h0000_7f05);
    `CHK("trim", 7'h7f, trim_code)
    `CHK("offset", 63, u_ref.osc_offset)
    wr(OFF_CFG, 32'h0004_0258);
    chk_reg(OFF_CFG, 32'h0004_0258);
    wr(OFF_CTRL, 32'h0000_7f65);
    wr(OFF_CTRL, 32'h0000_7fe5);
    t_last = cyc;
    chk_reg(OFF_CTRL, 32'h0000_7f65);
    eval(30, 32'h104, 7'h7f, 1'h1, 567, 1'h0);
    eval(300, 32'h406, 7'h7f, 1'h1, 300, 1'h0);
    $display("test error and overflow done");
    wr(OFF_CTRL, 32'h0000_0105);
    wr(OFF_CTRL, 32'h0000_0125);
    wr(OFF_CTRL, 32'h0000_01a5);
    t_last = cyc;
    eval(651, 32'h002, 7'h01, 1'h0, 53, 1'h1);
    wr(OFF_CTRL, 32'h0000_0165);
    eval(651, 32'h406, 7'h00, 1'h1, 50, 1'h1);
    $display("test underflow done");
    give_verdict();
  end
endmodule
